/* File: common/phase_recovery_pkg.sv */
// Constants for the phase recovery control and status registers.
// Assumes a byte-wide register space reached through the two-wire serial port.
package phase_recovery_pkg;
    // Register byte addresses, most significant byte at the lower address
    localparam logic [7:0] ADDR_RECOVERY_CTRL = 8'h44;
    localparam logic [7:0] ADDR_PHASE_RANGE = 8'h45;
    localparam logic [7:0] ADDR_WAIT_HI = 8'h46;
    localparam logic [7:0] ADDR_WAIT_MID = 8'h47;
    localparam logic [7:0] ADDR_WAIT_LO = 8'h48;
    localparam logic [7:0] ADDR_PHASE_MODE = 8'h49;
    localparam logic [7:0] ADDR_OFFSET_HI = 8'h4A;
    localparam logic [7:0] ADDR_OFFSET_LO = 8'h4B;
    localparam logic [7:0] ADDR_TOTAL_HI = 8'h4C;
    localparam logic [7:0] ADDR_TOTAL_LO = 8'h4D;
    localparam logic [7:0] ADDR_STATUS = 8'h4E;
    // Field positions
    localparam int BIT_TRACK_EN = 3;
    localparam int BIT_AUTO_CAL_EN = 4;
    localparam int BIT_QUICK = 0;
    localparam int BIT_AUTO_TOTAL = 1;
    localparam int BIT_STANDALONE = 2;
    localparam int BIT_DIGITAL = 3;
    localparam int BIT_HSIZE_READY = 4;
    localparam int BIT_QUALITY_READY = 3;
    // Reset values
    localparam logic [7:0] RST_RECOVERY_CTRL = 8'h71;
    localparam logic [3:0] RST_PHASE_RANGE = 4'h0;
    localparam logic [23:0] RST_FRAME_WAIT = 24'h000000;
    localparam logic [3:0] RST_PHASE_MODE = 4'h2;
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_TOTAL = 16'h0000;
    // Serial port
    localparam int SYNC_STAGES = 3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_WR_ACK, ST_WDATA, ST_RDATA, ST_RD_ACK
    } serial_state_t;
endpackage

/* File: src/phase_recovery_control_regs.sv */
// Phase recovery control and status registers behind a two-wire serial slave.
// Assumes engine inputs are synchronous to clock_i; scl/sda come from pins.
`timescale 1ns/10ps
`default_nettype none
module phase_recovery_control_regs
    import phase_recovery_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary slave address
    parameter int FRAME_WAIT_W = 24,        // Frame wait count width
    parameter int PHASE_W = 10              // Phase value width
) (
    input wire logic clock_i,                        // 10 MHz clock
    input wire logic rstn_i,                         // Async reset, active low
    input wire logic scl_i,                          // Serial clock pin
    input wire logic sda_i,                          // Serial data pin level
    output logic sda_o,                              // Serial data drive level
    output logic sda_oe_n_o,                         // Low while driving sda
    input wire logic frame_tick_i,                   // One pulse per frame
    input wire logic [PHASE_W-1:0] calibrated_phase_i, // From calibration engine
    input wire logic manual_freq_state_i,            // Manual frequency state
    input wire logic hsize_done_i,                   // Hsize measured pulse
    input wire logic manual_phase_state_i,           // Manual phase state
    input wire logic quality_done_i,                 // Quality measured pulse
    output logic track_adjust_o,                     // Tracking adjust pulse
    output logic [PHASE_W-1:0] final_phase_o,        // Phase to apply
    output logic [3:0] phase_range_o,                // Tracking phase range
    output logic track_en_o,                         // Phase tracking enable
    output logic auto_cal_en_o,                      // Auto phase cal enable
    output logic auto_total_en_o,                    // Auto total calc enable
    output logic standalone_o,                       // Use internal sync timing
    output logic digital_o                           // Digital input selected
);
    if (FRAME_WAIT_W < 17 || FRAME_WAIT_W > 24 || PHASE_W < 9 || PHASE_W > 16)
    begin : g_bad_params
        $error("Widths do not fit the register byte layout");
    end

    // Pin synchronisers; a level change counts when stages 2 and 3 agree
    logic [SYNC_STAGES-1:0] scl_sync_reg;
    logic [SYNC_STAGES-1:0] sda_sync_reg;
    logic scl_lvl_reg;
    logic sda_lvl_reg;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scl_sync_reg <= '1;
            sda_sync_reg <= '1;
            scl_lvl_reg <= 1'b1;
            sda_lvl_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_lvl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_lvl_reg <= sda_sync_reg[2];
        end
    end
    wire scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_lvl_reg;
    wire sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_lvl_reg;
    wire scl_rise = scl_next & ~scl_lvl_reg;
    wire scl_fall = ~scl_next & scl_lvl_reg;
    wire start_seen = scl_lvl_reg & scl_next & sda_lvl_reg & ~sda_next;
    wire stop_seen = scl_lvl_reg & scl_next & ~sda_lvl_reg & sda_next;

    // Register storage
    logic [7:0] recovery_ctrl_reg;
    logic [3:0] phase_range_reg;
    logic [23:0] frame_wait_reg;
    logic [3:0] phase_mode_reg;
    logic [15:0] offset_reg;
    logic [15:0] total_reg;
    logic hsize_ready_reg;
    logic quality_ready_reg;

    // Serial slave state
    serial_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic drive_low_reg;
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;

    wire [7:0] status_byte = {3'h0, hsize_ready_reg, quality_ready_reg, 3'h0};
    wire [7:0] rd_byte =
        (ptr_reg == ADDR_RECOVERY_CTRL) ? recovery_ctrl_reg :
        (ptr_reg == ADDR_PHASE_RANGE) ? {4'h0, phase_range_reg} :
        (ptr_reg == ADDR_WAIT_HI) ? frame_wait_reg[23:16] :
        (ptr_reg == ADDR_WAIT_MID) ? frame_wait_reg[15:8] :
        (ptr_reg == ADDR_WAIT_LO) ? frame_wait_reg[7:0] :
        (ptr_reg == ADDR_PHASE_MODE) ? {4'h0, phase_mode_reg} :
        (ptr_reg == ADDR_OFFSET_HI) ? offset_reg[15:8] :
        (ptr_reg == ADDR_OFFSET_LO) ? offset_reg[7:0] :
        (ptr_reg == ADDR_TOTAL_HI) ? total_reg[15:8] :
        (ptr_reg == ADDR_TOTAL_LO) ? total_reg[7:0] :
        (ptr_reg == ADDR_STATUS) ? status_byte : 8'h00;
    wire byte_done = (bit_cnt_reg == BITS_PER_BYTE);
    wire addr_match = (shift_reg[7:1] == DEV_ADDR);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            drive_low_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end
        else
        begin
            wr_stb_reg <= 1'b0;
            if (start_seen)
            begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                drive_low_reg <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_reg <= ST_IDLE;
                drive_low_reg <= 1'b0;
            end
            else if (scl_rise && state_reg != ST_IDLE)
            begin
                shift_reg <= {shift_reg[6:0], sda_next};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall)
            begin
                case (state_reg)
                    ST_ADDR:
                        if (byte_done)
                        begin
                            state_reg <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                            drive_low_reg <= addr_match;
                            rw_reg <= shift_reg[0];
                        end
                    ST_ADDR_ACK:
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg)
                        begin
                            drive_low_reg <= ~rd_byte[7];
                            tx_reg <= {rd_byte[6:0], 1'b1};
                            ptr_reg <= ptr_reg + 8'h01;
                            state_reg <= ST_RDATA;
                        end
                        else
                        begin
                            drive_low_reg <= 1'b0;
                            state_reg <= ST_PTR;
                        end
                    end
                    ST_PTR:
                        if (byte_done)
                        begin
                            ptr_reg <= shift_reg;
                            drive_low_reg <= 1'b1;
                            state_reg <= ST_WR_ACK;
                        end
                    ST_WDATA:
                        if (byte_done)
                        begin
                            wr_stb_reg <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= shift_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                            drive_low_reg <= 1'b1;
                            state_reg <= ST_WR_ACK;
                        end
                    ST_WR_ACK:
                    begin
                        drive_low_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_WDATA;
                    end
                    ST_RDATA:
                        if (byte_done)
                        begin
                            drive_low_reg <= 1'b0;
                            state_reg <= ST_RD_ACK;
                        end
                        else
                        begin
                            drive_low_reg <= ~tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b1};
                        end
                    ST_RD_ACK:
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (shift_reg[0])
                            state_reg <= ST_IDLE;
                        else
                        begin
                            drive_low_reg <= ~rd_byte[7];
                            tx_reg <= {rd_byte[6:0], 1'b1};
                            ptr_reg <= ptr_reg + 8'h01;
                            state_reg <= ST_RDATA;
                        end
                    end
                    default:
                        drive_low_reg <= 1'b0;
                endcase
            end
        end
    end

    // Register writes; status byte and unmapped addresses ignore writes
    wire wr_ctrl = wr_stb_reg && (wr_addr_reg == ADDR_RECOVERY_CTRL);
    wire wr_range = wr_stb_reg && (wr_addr_reg == ADDR_PHASE_RANGE);
    wire wr_wait_hi = wr_stb_reg && (wr_addr_reg == ADDR_WAIT_HI);
    wire wr_wait_mid = wr_stb_reg && (wr_addr_reg == ADDR_WAIT_MID);
    wire wr_wait_lo = wr_stb_reg && (wr_addr_reg == ADDR_WAIT_LO);
    wire wr_mode = wr_stb_reg && (wr_addr_reg == ADDR_PHASE_MODE);
    wire wr_off_hi = wr_stb_reg && (wr_addr_reg == ADDR_OFFSET_HI);
    wire wr_off_lo = wr_stb_reg && (wr_addr_reg == ADDR_OFFSET_LO);
    wire wr_tot_hi = wr_stb_reg && (wr_addr_reg == ADDR_TOTAL_HI);
    wire wr_tot_lo = wr_stb_reg && (wr_addr_reg == ADDR_TOTAL_LO);
    localparam logic [23:0] WAIT_MASK = 24'((64'h1 << FRAME_WAIT_W) - 64'h1);
    localparam logic [15:0] PHASE_MASK = 16'((32'h1 << PHASE_W) - 32'h1);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            recovery_ctrl_reg <= RST_RECOVERY_CTRL;
            phase_range_reg <= RST_PHASE_RANGE;
            frame_wait_reg <= RST_FRAME_WAIT;
            phase_mode_reg <= RST_PHASE_MODE;
            offset_reg <= RST_OFFSET;
            total_reg <= RST_TOTAL;
        end
        else
        begin
            if (wr_ctrl)
                recovery_ctrl_reg <= wr_data_reg;
            if (wr_range)
                phase_range_reg <= wr_data_reg[3:0];
            if (wr_wait_hi)
                frame_wait_reg[23:16] <= wr_data_reg & WAIT_MASK[23:16];
            if (wr_wait_mid)
                frame_wait_reg[15:8] <= wr_data_reg;
            if (wr_wait_lo)
                frame_wait_reg[7:0] <= wr_data_reg;
            if (wr_mode)
                phase_mode_reg <= wr_data_reg[3:0];
            if (wr_off_hi)
                offset_reg[15:8] <= wr_data_reg & PHASE_MASK[15:8];
            if (wr_off_lo)
                offset_reg[7:0] <= wr_data_reg;
            if (wr_tot_hi)
                total_reg[15:8] <= wr_data_reg & PHASE_MASK[15:8];
            if (wr_tot_lo)
                total_reg[7:0] <= wr_data_reg;
        end
    end

    // Ready flags: set by the engine while its manual state holds, drop on exit
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hsize_ready_reg <= 1'b0;
            quality_ready_reg <= 1'b0;
        end
        else
        begin
            hsize_ready_reg <= manual_freq_state_i & (hsize_ready_reg | hsize_done_i);
            quality_ready_reg <= manual_phase_state_i
                & (quality_ready_reg | quality_done_i);
        end
    end

    // Frame wait counter ahead of each tracking adjustment
    logic [23:0] frame_cnt_reg;
    logic track_adjust_reg;
    wire tracking = recovery_ctrl_reg[BIT_TRACK_EN];
    wire wait_reached = (frame_cnt_reg >= frame_wait_reg);
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            frame_cnt_reg <= 24'h000000;
            track_adjust_reg <= 1'b0;
        end
        else
        begin
            track_adjust_reg <= tracking & frame_tick_i & wait_reached;
            if (!tracking)
                frame_cnt_reg <= 24'h000000;
            else if (frame_tick_i)
                frame_cnt_reg <= wait_reached ? 24'h000000 : frame_cnt_reg + 24'h000001;
        end
    end

    // Final phase and control outputs
    wire [PHASE_W-1:0] quick_phase = total_reg[PHASE_W-1:0] - offset_reg[PHASE_W-1:0];
    wire quick_sel = phase_mode_reg[BIT_QUICK];
    logic [PHASE_W-1:0] final_phase_reg;
    logic sda_level_reg;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            final_phase_reg <= '0;
            sda_level_reg <= 1'b0;
        end
        else
        begin
            final_phase_reg <= quick_sel ? quick_phase : calibrated_phase_i;
            sda_level_reg <= 1'b0;
        end
    end

    assign sda_o = sda_level_reg;
    assign sda_oe_n_o = ~drive_low_reg;
    assign track_adjust_o = track_adjust_reg;
    assign final_phase_o = final_phase_reg;
    assign phase_range_o = phase_range_reg;
    assign track_en_o = recovery_ctrl_reg[BIT_TRACK_EN];
    assign auto_cal_en_o = recovery_ctrl_reg[BIT_AUTO_CAL_EN];
    assign auto_total_en_o = phase_mode_reg[BIT_AUTO_TOTAL];
    assign standalone_o = phase_mode_reg[BIT_STANDALONE];
    assign digital_o = phase_mode_reg[BIT_DIGITAL];
endmodule // phase_recovery_control_regs
`default_nettype wire

/* File: verif/phase_recovery_checker.sv */
// Port checker for the phase recovery register block.
// Assumes bind to the top module and serial clock phases of eight clocks.
`timescale 1ns/10ps
`default_nettype none
module phase_recovery_checker #(
    parameter int PHASE_W = 10 // Phase value width
) (
    input wire logic clock_i, // Clock
    input wire logic rstn_i, // Reset, active low
    input wire logic scl_i, // Serial clock pin
    input wire logic frame_tick_i, // Frame pulse
    input wire logic [PHASE_W-1:0] calibrated_phase_i, // Engine phase
    input wire logic track_adjust_o, // Adjust pulse
    input wire logic [PHASE_W-1:0] final_phase_o, // Applied phase
    input wire logic track_en_o, // Tracking enable
    input wire logic auto_cal_en_o, // Auto calibration enable
    input wire logic auto_total_en_o, // Auto total enable
    input wire logic standalone_o, // Internal sync timing
    input wire logic digital_o // Digital input
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Register writes land only while the serial clock has been low a while
    property p_rst_defaults; $rose(rstn_i) |-> auto_total_en_o && !standalone_o; endproperty
    a_rst_defaults: assert property (p_rst_defaults) else $error("bad reset level");
    property p_adjust_cause; track_adjust_o |-> $past(frame_tick_i) && $past(track_en_o); endproperty
    a_adjust_cause: assert property (p_adjust_cause) else $error("adjust without tick");
    property p_adjust_single; track_adjust_o && !frame_tick_i |=> !track_adjust_o; endproperty
    a_adjust_single: assert property (p_adjust_single) else $error("adjust too long");
    property p_track_off; !track_en_o [*2] |-> !track_adjust_o; endproperty
    a_track_off: assert property (p_track_off) else $error("adjust while off");
    property p_sync_write; $changed(standalone_o) |-> !scl_i && !$past(scl_i, 3); endproperty
    a_sync_write: assert property (p_sync_write) else $error("sync select moved");
    property p_digital_write; $changed(digital_o) |-> !scl_i && !$past(scl_i, 3); endproperty
    a_digital_write: assert property (p_digital_write) else $error("input select moved");
    property p_total_write; $changed(auto_total_en_o) |-> !scl_i && !$past(scl_i, 3); endproperty
    a_total_write: assert property (p_total_write) else $error("total enable moved");
    property p_ctrl_write;
        $changed(track_en_o) || $changed(auto_cal_en_o) |-> !scl_i && !$past(scl_i, 3);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control bit moved");
    property p_final_follow;
        $changed(final_phase_o) && scl_i |-> final_phase_o == $past(calibrated_phase_i);
    endproperty
    a_final_follow: assert property (p_final_follow) else $error("final phase moved");
endmodule // phase_recovery_checker
`default_nettype wire

/* File: verif/serial_host_model.sv */
// Host side of the two-wire serial port: a master reading and writing registers.
// Assumes a pulled-up data wire whose level comes back on sda_i.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
    input wire logic clock_i, // Bench clock
    input wire logic sda_i, // Data wire level
    output logic scl_o, // Serial clock
    output logic sda_o // Data drive, 1 releases
);
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    task automatic hold(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // Both clock phases last eight clocks, data set mid low phase
    task automatic bit_io(input logic b, output logic r);
        hold(4);
        sda_o = b;
        hold(4);
        scl_o = 1'b1;
        hold(4);
        r = sda_i;
        hold(4);
        scl_o = 1'b0;
    endtask
    task automatic edge_pair(input logic a, input logic b);
        hold(4);
        sda_o = a;
        hold(4);
        scl_o = 1'b1;
        hold(4);
        sda_o = b;
        hold(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ak, n);
    endtask
    task automatic write_reg(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
        output logic ok);
        logic [7:0] q;
        logic [2:0] n;
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
        xfer({dv, 1'b0}, 1'b1, q, n[0]);
        xfer(a, 1'b1, q, n[1]);
        xfer(d, 1'b1, q, n[2]);
        edge_pair(1'b0, 1'b1);
        ok = (n === 3'b000);
    endtask
    task automatic read_reg(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
        output logic ok);
        logic [7:0] q;
        logic [2:0] n;
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
        xfer({dv, 1'b0}, 1'b1, q, n[0]);
        xfer(a, 1'b1, q, n[1]);
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
        xfer({dv, 1'b1}, 1'b1, q, n[2]);
        xfer(8'hFF, 1'b1, d, q[0]);
        edge_pair(1'b0, 1'b1);
        ok = (n === 3'b000);
    endtask
    // Two-byte read: the host acknowledges the first byte, refuses the second
    task automatic read_two(input logic [6:0] dv, input logic [7:0] a, output logic [15:0] d,
        output logic ok);
        logic [7:0] q;
        logic [2:0] n;
        logic m;
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
        xfer({dv, 1'b0}, 1'b1, q, n[0]);
        xfer(a, 1'b1, q, n[1]);
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
        xfer({dv, 1'b1}, 1'b1, q, n[2]);
        xfer(8'hFF, 1'b0, q, m);
        d[15:8] = q;
        xfer(8'hFF, 1'b1, q, m);
        d[7:0] = q;
        edge_pair(1'b0, 1'b1);
        ok = (n === 3'b000);
    endtask
endmodule // serial_host_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the phase recovery register block.
// Assumes the host model timing; expected values are queued and matched in order.
`timescale 1ns/10ps
`default_nettype none
module tb
    import phase_recovery_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2A;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic scl, host_sda, oe_n, tick = 1'b0, mfreq = 1'b0, hdone = 1'b0, mphase = 1'b0;
    logic qdone = 1'b0, adj, t_en, c_en, a_en, stand, dig, ok, sda_lvl;
    logic [15:0] pair;
    logic [9:0] cal = 10'h000, fin, offset, total;
    logic [3:0] range;
    logic [23:0] exp_q[$];
    logic [23:0] seen;
    string seen_name;
    event seen_ev;
    int fail_count = 0, num_checks = 0, adj_count = 0, seed = 33;
    wire sda_wire = host_sda & oe_n;
    phase_recovery_control_regs #(.DEV_ADDR(DEV)) i_phase_recovery_control_regs (
        .clock_i(clock_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_lvl),
        .sda_oe_n_o(oe_n), .frame_tick_i(tick), .calibrated_phase_i(cal),
        .manual_freq_state_i(mfreq), .hsize_done_i(hdone), .manual_phase_state_i(mphase),
        .quality_done_i(qdone), .track_adjust_o(adj), .final_phase_o(fin),
        .phase_range_o(range), .track_en_o(t_en), .auto_cal_en_o(c_en),
        .auto_total_en_o(a_en), .standalone_o(stand), .digital_o(dig));
    serial_host_model i_serial_host_model (
        .clock_i(clock_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));
    initial forever #50 clock_i = ~clock_i;
    always @(negedge clock_i) if (adj === 1'b1) adj_count++;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic look(input string nm, input logic [23:0] e, input logic [23:0] v);
        exp_q.push_back(e);
        seen_name = nm;
        seen = v;
        -> seen_ev;
        @(negedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_serial_host_model.write_reg(DEV, a, d, ok);
        look("write ack", 24'h1, {23'h0, ok});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_serial_host_model.read_reg(DEV, a, d, ok);
        look($sformatf("reg %h", a), {15'h0, 1'b1, e}, {15'h0, ok, d});
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock_i);
        s = 1'b0;
        repeat (5) @(negedge clock_i);
    endtask
    initial
    begin
        forever
        begin
            @(seen_ev);
            num_checks++;
            if (seen !== exp_q[0])
            begin
                $display("wrong value %s expected %h seen %h", seen_name, exp_q[0], seen);
                fail_count++;
            end
            void'(exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (100000) @(posedge clock_i);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        look("reset enables", 24'h3, {22'h0, a_en, c_en});
        look("drive level", 24'h0, {23'h0, sda_lvl});
        rd(ADDR_RECOVERY_CTRL, 8'h71);
        rd(ADDR_PHASE_MODE, {4'h0, RST_PHASE_MODE});
        wr(ADDR_WAIT_HI, 8'hA5);
        wr(ADDR_WAIT_MID, 8'h3C);
        rd(ADDR_WAIT_HI, 8'hA5);
        rd(ADDR_WAIT_MID, 8'h3C);
        wr(ADDR_WAIT_HI, 8'h00);
        wr(ADDR_WAIT_MID, 8'h00);
        wr(ADDR_WAIT_LO, 8'h02);
        wr(ADDR_RECOVERY_CTRL, 8'h79);
        look("track enable", 24'h1, {23'h0, t_en});
        repeat (7) pulse(tick);
        look("adjust count", 24'h2, adj_count[23:0]);
        wr(ADDR_RECOVERY_CTRL, 8'h61);
        repeat (4) pulse(tick);
        look("adjust off", 24'h4, {adj_count[22:0], c_en});
        wr(ADDR_PHASE_RANGE, 8'hFA);
        rd(ADDR_PHASE_RANGE, 8'h0A);
        look("range", 24'hA, {20'h0, range});
        offset = 10'($random(seed));
        total = 10'($random(seed));
        wr(ADDR_OFFSET_HI, {6'h3F, offset[9:8]});
        wr(ADDR_OFFSET_LO, offset[7:0]);
        wr(ADDR_TOTAL_HI, {6'h3F, total[9:8]});
        wr(ADDR_TOTAL_LO, total[7:0]);
        rd(ADDR_OFFSET_HI, {6'h00, offset[9:8]});
        rd(ADDR_TOTAL_HI, {6'h00, total[9:8]});
        i_serial_host_model.read_two(DEV, ADDR_OFFSET_HI, pair, ok);
        look("offset pair", {7'h0, 1'b1, 6'h00, offset}, {7'h0, ok, pair});
        // The last mode leaves the digital input selected
        for (int m = 0; m < 16; m++)
        begin
            cal = 10'($random(seed));
            wr(ADDR_PHASE_MODE, 8'(m));
            rd(ADDR_PHASE_MODE, 8'(m));
            look("final", {14'h0, m[0] ? 10'(total - offset) : cal}, {14'h0, fin});
            look("modes", 24'(m[3:1]), {21'h0, dig, stand, a_en});
        end
        pulse(qdone);
        mfreq = 1'b1;
        pulse(hdone);
        rd(ADDR_STATUS, 8'h10);
        mphase = 1'b1;
        pulse(qdone);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h18);
        mfreq = 1'b0;
        mphase = 1'b0;
        rd(ADDR_STATUS, 8'h00);
        wr(8'h60, 8'h55);
        rd(8'h60, 8'h00);
        i_serial_host_model.write_reg(DEV ^ 7'h01, ADDR_PHASE_MODE, 8'h00, ok);
        look("other device", 24'h0, {23'h0, ok});
        look("digital", 24'h1, {23'h0, dig});
        report_and_stop();
    end
endmodule // tb
bind phase_recovery_control_regs phase_recovery_checker #(.PHASE_W(PHASE_W)) i_phase_recovery_checker (
    .clock_i, .rstn_i, .scl_i, .frame_tick_i, .calibrated_phase_i, .track_adjust_o,
    .final_phase_o, .track_en_o, .auto_cal_en_o, .auto_total_en_o, .standalone_o, .digital_o);
`default_nettype wire
